//--- rtl/nv_seq_pkg.sv
// Purpose: Shared constants for the shadow-RAM write and nonvolatile copy slave
// Assumes: 20 MHz system clock
// Notes: Register pointer values are bus register addresses, not byte offsets
package nv_seq_pkg;
   // Bus identity: upper four bits of the 7-bit slave address
   localparam logic [3:0] DEV_ID = 4'h9;
   // Register map
   localparam logic [7:0] REG_FIRST = 8'hA0;
   localparam logic [7:0] REG_LAST = 8'hAD;
   localparam logic [7:0] REG_USER0 = 8'hA4;
   localparam logic [7:0] REG_GAP0 = 8'hA8;
   localparam logic [7:0] REG_GAP1 = 8'hA9;
   localparam logic [7:0] REG_CFG_MSB = 8'hAC;
   localparam logic [7:0] RD_PAST_END = 8'hFF;
   localparam int NREGS = 14;
   localparam logic [3:0] CFG_IDX = 4'hC;
   // Configuration MSB fields and reset value
   localparam int CFG_SINGLE_BIT = 0;
   localparam int CFG_NVB_BIT = 3;
   localparam logic [7:0] CFG_MSB_RST = 8'h01;
   localparam logic [NREGS*8-1:0] SHADOW_RST = (NREGS*8)'(CFG_MSB_RST) << (8 * int'(CFG_IDX));
   // Command bytes
   localparam logic [7:0] CMD_START = 8'h51;
   localparam logic [7:0] CMD_STOP = 8'h22;
   localparam logic [7:0] CMD_COPY = 8'h48;
   localparam logic [7:0] CMD_RECALL = 8'hB8;
   localparam logic [7:0] CMD_POR = 8'h54;
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int COPY_TIME_MS = 10;
   localparam int CONV_TIME_MS = 200;
   localparam int COPY_CYC = COPY_TIME_MS * (CLK_HZ / 1000);
   localparam int CONV_CYC = CONV_TIME_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 22;
   // Bit counter
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

//--- rtl/link_evt_if.sv
// Purpose: Synchronised two-wire levels and events from sampler to slave core
// Assumes: All signals on the system clock
// Notes: Events are one-cycle pulses
`timescale 1ns/10ps
interface link_evt_if;
   logic scl;
   logic sda;
   logic [2:0] addr_sel;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output scl, output sda, output addr_sel, output scl_rise, output scl_fall, output start,
                output stop);
   modport snk (input scl, input sda, input addr_sel, input scl_rise, input scl_fall, input start,
                input stop);
endinterface

//--- rtl/link_sampler.sv
// Purpose: Two-flop synchronisers and edge, start and stop detection for the serial pins
// Assumes: Serial clock well below a quarter of the system clock
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module link_sampler
   import nv_seq_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [2:0] i_addr_sel,
   // Events
   link_evt_if.src lk
);
   typedef struct packed
   {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [1:0] s3;
   } smp_t;

   localparam smp_t SMP_RST = '{s1: 5'h18, s2: 5'h18, s3: 2'h3};

   smp_t smp_q;
   smp_t smp_d;

   always_comb
   begin
      smp_d = smp_q;
      smp_d.s1 = {i_scl, i_sda, i_addr_sel};
      smp_d.s2 = smp_q.s1;
      smp_d.s3 = smp_q.s2[4:3];
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         smp_q <= SMP_RST;
      else
         smp_q <= smp_d;
   end

   assign lk.scl = smp_q.s2[4];
   assign lk.sda = smp_q.s2[3];
   assign lk.addr_sel = smp_q.s2[2:0];
   assign lk.scl_rise = smp_q.s2[4] & ~smp_q.s3[1];
   assign lk.scl_fall = ~smp_q.s2[4] & smp_q.s3[1];
   // Data edges while clock stays high
   assign lk.start = smp_q.s2[4] & smp_q.s3[1] & smp_q.s3[0] & ~smp_q.s2[3];
   assign lk.stop = smp_q.s2[4] & smp_q.s3[1] & ~smp_q.s3[0] & smp_q.s2[3];
endmodule

//--- rtl/nv_copy_slave.sv
// Purpose: Two-wire slave holding shadow RAM, configuration and nonvolatile copy
// Assumes: Serial pins asynchronous to i_sys_clk; open-drain data pin
// Notes: Nonvolatile array is modelled as flops with a timed busy flag
//
// Overview of operation
// - Byte after acknowledged control byte loads the pointer; A4h is first user byte.
// - Each data byte lands in shadow RAM at the pointer unless it is a gap or outside the map; the pointer then advances.
// - Pointer ACh selects configuration MSB; writes go to shadow RAM only.
// - Configuration byte with bit zero clear selects continuous conversion.
// - Copy command works only in continuous mode while converting.
// - Command 51h starts temperature conversions as its acknowledge begins.
// - Command 48h copies all shadow RAM registers into nonvolatile storage.
`timescale 1ns/10ps
module nv_copy_slave
   import nv_seq_pkg::*;
#(
   parameter int unsigned P_COPY_CYC = COPY_CYC,
   parameter int unsigned P_CONV_CYC = CONV_CYC
)
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Serial pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic [2:0] i_addr_sel,
   // Status
   output logic o_single_conversion_select,
   output logic o_converting,
   output logic o_nonvolatile_write_busy
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TXACK = 3'b100
   } state_t;

   typedef enum logic [1:0]
   {
      K_CTRL = 2'b00,
      K_REG = 2'b01,
      K_DATA = 2'b10
   } kind_t;

   typedef struct packed
   {
      state_t st;
      kind_t kind;
      logic rw;
      logic more;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic oe;
      logic converting;
      logic nv_busy;
      logic [CNT_W-1:0] copy_cnt;
      logic [CNT_W-1:0] conv_cnt;
      logic [NREGS-1:0][7:0] shadow;
      logic [NREGS-1:0][7:0] nv;
   } core_t;

   localparam core_t CORE_RST = '{st: ST_IDLE, kind: K_CTRL, rw: 1'b0, more: 1'b0, cnt: 4'h0, shift: 8'h00,
                                  ptr: 8'h00, oe: 1'b0, converting: 1'b0, nv_busy: 1'b0,
                                  copy_cnt: '0, conv_cnt: '0, shadow: SHADOW_RST, nv: SHADOW_RST};

   link_evt_if lk ();

   core_t q;
   core_t d;
   logic single_q;
   logic byte_done;
   logic [7:0] rd_now;

   link_sampler u_sampler
   (
      .i_sys_clk (i_sys_clk),
      .i_rst_b (i_rst_b),
      .i_scl (i_scl),
      .i_sda (i_sda),
      .i_addr_sel (i_addr_sel),
      .lk (lk)
   );

   function automatic logic in_map(input logic [7:0] p);
      return (p >= REG_FIRST) && (p <= REG_LAST);
   endfunction

   function automatic logic [3:0] reg_idx(input logic [7:0] p);
      logic [7:0] diff;
      diff = p - REG_FIRST;
      return diff[3:0];
   endfunction

   // Undefined gap registers swallow writes
   function automatic logic writable(input logic [7:0] p);
      return in_map(p) && (p != REG_GAP0) && (p != REG_GAP1);
   endfunction

   function automatic logic is_cmd(input logic [7:0] b);
      return (b == CMD_START) || (b == CMD_STOP) || (b == CMD_COPY) || (b == CMD_RECALL) || (b == CMD_POR);
   endfunction

   // Read value; busy flag shown live in configuration MSB
   function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [NREGS-1:0][7:0] sh,
                                          input logic busy);
      logic [7:0] v;
      v = RD_PAST_END;
      if (in_map(p))
      begin
         v = sh[reg_idx(p)];
         if (reg_idx(p) == CFG_IDX)
            v[CFG_NVB_BIT] = busy;
      end
      return v;
   endfunction

   assign single_q = q.shadow[CFG_IDX][CFG_SINGLE_BIT];
   assign byte_done = (q.st == ST_RX) && (q.cnt == BITS_PER_BYTE) && lk.scl_fall && !lk.start && !lk.stop;
   assign rd_now = rd_byte(q.ptr, q.shadow, q.nv_busy);

   always_comb
   begin
      d = q;
      if (q.nv_busy)
      begin
         if (q.copy_cnt == '0)
            d.nv_busy = 1'b0;
         else
            d.copy_cnt = q.copy_cnt - 1'b1;
      end
      // A single conversion ends on its own
      if (q.converting && single_q)
      begin
         if (q.conv_cnt == '0)
            d.converting = 1'b0;
         else
            d.conv_cnt = q.conv_cnt - 1'b1;
      end
      if (lk.stop)
      begin
         d.st = ST_IDLE;
         d.oe = 1'b0;
      end
      else if (lk.start)
      begin
         d.st = ST_RX;
         d.kind = K_CTRL;
         d.cnt = 4'h0;
         d.oe = 1'b0;
      end
      else
      begin
         unique case (q.st)
            ST_IDLE:
            begin
            end
            ST_RX:
            begin
               if (lk.scl_rise && (q.cnt != BITS_PER_BYTE))
               begin
                  d.shift = {q.shift[6:0], lk.sda};
                  d.cnt = q.cnt + 4'h1;
               end
               else if (byte_done)
               begin
                  d.st = ST_ACK;
                  d.oe = 1'b1;
                  unique case (q.kind)
                     K_CTRL:
                     begin
                        if (q.shift[7:1] == {DEV_ID, lk.addr_sel})
                           d.rw = q.shift[0];
                        else
                        begin
                           d.st = ST_IDLE;
                           d.oe = 1'b0;
                        end
                     end
                     K_REG:
                     begin
                        if (!is_cmd(q.shift))
                           d.ptr = q.shift;
                        else
                        begin
                           d.ptr = RD_PAST_END;
                           unique case (q.shift)
                              CMD_START:
                              begin
                                 d.converting = 1'b1;
                                 d.conv_cnt = CNT_W'(P_CONV_CYC);
                              end
                              CMD_STOP:
                              begin
                                 if (!single_q)
                                    d.converting = 1'b0;
                              end
                              CMD_COPY:
                              begin
                                 if (!single_q && q.converting && !q.nv_busy)
                                 begin
                                    d.nv = q.shadow;
                                    d.nv_busy = 1'b1;
                                    d.copy_cnt = CNT_W'(P_COPY_CYC);
                                 end
                              end
                              CMD_RECALL:
                              begin
                                 if (!q.nv_busy)
                                    d.shadow = q.nv;
                              end
                              CMD_POR:
                              begin
                                 d = CORE_RST;
                                 d.nv = q.nv;
                                 d.st = ST_ACK;
                                 d.oe = 1'b1;
                                 d.kind = K_REG;
                                 d.ptr = RD_PAST_END;
                              end
                              default:
                              begin
                              end
                           endcase
                        end
                     end
                     K_DATA:
                     begin
                        if (writable(q.ptr))
                           d.shadow[reg_idx(q.ptr)] = q.shift;
                        d.ptr = q.ptr + 8'h01;
                     end
                     default:
                     begin
                        d.st = ST_IDLE;
                        d.oe = 1'b0;
                     end
                  endcase
               end
            end
            ST_ACK:
            begin
               if (lk.scl_fall)
               begin
                  if ((q.kind == K_CTRL) && q.rw)
                  begin
                     d.st = ST_TX;
                     d.shift = rd_now;
                     d.oe = ~rd_now[7];
                     d.cnt = 4'h1;
                     d.kind = K_DATA;
                     d.ptr = q.ptr + 8'h01;
                  end
                  else
                  begin
                     d.st = ST_RX;
                     d.oe = 1'b0;
                     d.cnt = 4'h0;
                     d.kind = (q.kind == K_CTRL) ? K_REG : K_DATA;
                  end
               end
            end
            ST_TX:
            begin
               if (lk.scl_fall)
               begin
                  if (q.cnt == BITS_PER_BYTE)
                  begin
                     d.oe = 1'b0;
                     d.more = 1'b0;
                     d.st = ST_TXACK;
                  end
                  else
                  begin
                     d.shift = {q.shift[6:0], 1'b0};
                     d.oe = ~q.shift[6];
                     d.cnt = q.cnt + 4'h1;
                  end
               end
            end
            ST_TXACK:
            begin
               if (lk.scl_rise)
                  d.more = ~lk.sda;
               else if (lk.scl_fall)
               begin
                  if (q.more)
                  begin
                     d.st = ST_TX;
                     d.shift = rd_now;
                     d.oe = ~rd_now[7];
                     d.cnt = 4'h1;
                     d.ptr = q.ptr + 8'h01;
                  end
                  else
                     d.st = ST_IDLE;
               end
            end
            default:
            begin
               d.st = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         q <= CORE_RST;
      else
         q <= d;
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe = q.oe;
   assign o_single_conversion_select = single_q;
   assign o_converting = q.converting;
   assign o_nonvolatile_write_busy = q.nv_busy;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   sequence reg_byte_s;
      byte_done && (q.kind == K_REG);
   endsequence

   sequence data_byte_s;
      byte_done && (q.kind == K_DATA);
   endsequence

   sequence cmd_s(logic [7:0] c);
      reg_byte_s ##0 (q.shift == c);
   endsequence

   ptr_load_a: assert property (reg_byte_s ##0 !is_cmd(q.shift) |=> q.ptr == $past(q.shift))
      else $error("pointer not loaded from register address byte");
   shadow_store_a: assert property (data_byte_s ##0 writable(q.ptr)
      |=> (q.shadow[reg_idx($past(q.ptr))] == $past(q.shift)) && (q.ptr == $past(q.ptr) + 8'h01))
      else $error("data byte not stored or pointer not advanced");
   cfg_shadow_only_a: assert property (data_byte_s ##0 (q.ptr == REG_CFG_MSB) |=> q.nv == $past(q.nv))
      else $error("configuration write reached nonvolatile storage");
   cont_mode_a: assert property (data_byte_s ##0 (q.ptr == REG_CFG_MSB) && !q.shift[0]
      |=> !o_single_conversion_select)
      else $error("continuous mode not selected");
   ack_drive_a: assert property (byte_done && ((q.kind != K_CTRL) || (q.shift[7:1] == {DEV_ID, lk.addr_sel}))
      |=> (o_sda_oe && !o_sda_out) [*3])
      else $error("acknowledge not driven");
   copy_gate_a: assert property (cmd_s(CMD_COPY) ##0 (single_q || !q.converting) && !q.nv_busy
      |=> !o_nonvolatile_write_busy)
      else $error("copy accepted outside continuous conversion");
   conv_start_a: assert property (cmd_s(CMD_START) |=> o_converting ##1 o_converting)
      else $error("conversions not started");
   copy_all_a: assert property (cmd_s(CMD_COPY) ##0 !single_q && q.converting && !q.nv_busy
      |=> o_nonvolatile_write_busy && (q.nv == $past(q.shadow)))
      else $error("shadow RAM not copied");
endmodule

//--- testbench/two_wire_master.sv
// Purpose: Behavioural two-wire bus master facing the shadow RAM slave
// Assumes: SCL period of eight system clocks, five low and three high
// Notes: Open drain; o_sda_rel high releases the data wire to its pull-up
`timescale 1ns/10ps
module two_wire_master
(
   // Clock
   input wire logic i_sys_clk,
   // Wire
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_rel
);
   initial
   begin
      o_scl = 1'b1;
      o_sda_rel = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   // Start from idle, or repeated start from SCL low
   task automatic start_c();
      wt(1);
      o_sda_rel = 1'b1;
      wt(4);
      o_scl = 1'b1;
      wt(4);
      o_sda_rel = 1'b0;
      wt(4);
      o_scl = 1'b0;
   endtask
   task automatic stop_c();
      wt(1);
      o_sda_rel = 1'b0;
      wt(4);
      o_scl = 1'b1;
      wt(4);
      o_sda_rel = 1'b1;
      wt(4);
   endtask
   // Data set one clock after SCL fall, wire sampled late in the high phase
   task automatic clk_bit(input logic b, output logic s);
      wt(1);
      o_sda_rel = b;
      wt(4);
      o_scl = 1'b1;
      wt(3);
      s = i_sda;
      o_scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic read_byte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(~mack, s);
   endtask
endmodule

//--- testbench/shadow_ram_to_eeprom_copy_seq_tb_top.sv
// Purpose: Self-checking bench for the shadow RAM write and copy slave
// Assumes: Shortened copy and conversion counts
// Notes: Data wire resolved from both open-drain parties
`timescale 1ns/10ps
module shadow_ram_to_eeprom_copy_seq_tb_top;
   import nv_seq_pkg::*;
   localparam int COPY_N = 50;
   localparam int CONV_N = 300;
   localparam logic [2:0] ASEL = 3'h5;
   logic i_sys_clk;
   logic i_rst_b;
   logic scl;
   logic sda_rel;
   logic sda;
   logic sda_oe;
   logic sda_out;
   logic single;
   logic conv;
   logic busy;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   // Pull-up wins unless the master pulls low or the slave enables its driver
   assign sda = sda_rel & (sda_oe ? sda_out : 1'b1);
   nv_copy_slave #(.P_COPY_CYC(COPY_N), .P_CONV_CYC(CONV_N)) dut
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_scl(scl),
      .i_sda(sda),
      .o_sda_out(sda_out),
      .o_sda_oe(sda_oe),
      .i_addr_sel(ASEL),
      .o_single_conversion_select(single),
      .o_converting(conv),
      .o_nonvolatile_write_busy(busy)
   );
   two_wire_master mst
   (
      .i_sys_clk(i_sys_clk),
      .i_sda(sda),
      .o_scl(scl),
      .o_sda_rel(sda_rel)
   );
   initial
   begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   task automatic close_out();
      if (n_fail == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Whole run needs well under this many cycles
   always @(posedge i_sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ctrl(input logic rw);
      logic a;
      mst.send_byte({DEV_ID, ASEL, rw}, a);
      chk("control ack", 8'h01, {7'h00, a});
   endtask
   task automatic put(input logic [7:0] b);
      logic a;
      mst.send_byte(b, a);
      chk("byte ack", 8'h01, {7'h00, a});
   endtask
   task automatic cmd(input logic [7:0] c);
      mst.start_c();
      ctrl(1'b0);
      put(c);
      mst.stop_c();
   endtask
   task automatic rd_chk(input logic [7:0] r, input int n, input logic [31:0] e);
      logic [7:0] d;
      mst.start_c();
      ctrl(1'b0);
      put(r);
      mst.start_c();
      ctrl(1'b1);
      for (int i = n - 1; i >= 0; i--)
      begin
         mst.read_byte(i != 0, d);
         chk("read data", e[i*8 +: 8], d);
      end
      mst.stop_c();
   endtask
   task automatic t_reset();
      chk("sda enable", 8'h00, {7'h00, sda_oe});
      chk("single select", 8'h01, {7'h00, single});
      chk("converting", 8'h00, {7'h00, conv});
      chk("nv busy", 8'h00, {7'h00, busy});
   endtask
   task automatic t_bad_addr();
      logic a;
      mst.start_c();
      mst.send_byte({DEV_ID, ~ASEL, 1'b0}, a);
      chk("foreign ack", 8'h00, {7'h00, a});
      mst.stop_c();
   endtask
   // Single mode: one conversion only, copy refused
   task automatic t_single();
      cmd(CMD_START);
      chk("converting", 8'h01, {7'h00, conv});
      cmd(CMD_COPY);
      chk("nv busy", 8'h00, {7'h00, busy});
      repeat (CONV_N + 20) @(negedge i_sys_clk);
      chk("converting", 8'h00, {7'h00, conv});
      cmd(CMD_COPY);
      chk("nv busy", 8'h00, {7'h00, busy});
   endtask
   task automatic t_user_write();
      mst.start_c();
      ctrl(1'b0);
      put(REG_USER0);
      for (int i = 1; i <= 4; i++)
         put(8'(8'h11 * i));
      // Rewrite needed only while single conversion is selected
      chk("single select", 8'h01, {7'h00, single});
      mst.start_c();
      ctrl(1'b0);
      put(REG_CFG_MSB);
      put(8'hFE);
      mst.stop_c();
      chk("single select", 8'h00, {7'h00, single});
      rd_chk(REG_USER0, 4, 32'h11223344);
      rd_chk(REG_CFG_MSB, 1, 32'h000000F6);
   endtask
   task automatic t_copy();
      int k;
      cmd(CMD_START);
      repeat (CONV_N + 20) @(negedge i_sys_clk);
      chk("converting", 8'h01, {7'h00, conv});
      cmd(CMD_COPY);
      chk("nv busy", 8'h01, {7'h00, busy});
      for (k = 0; k < COPY_N + 10 && busy !== 1'b0; k++)
         @(negedge i_sys_clk);
      chk("nv busy", 8'h00, {7'h00, busy});
      cmd(CMD_STOP);
      chk("converting", 8'h00, {7'h00, conv});
      mst.start_c();
      ctrl(1'b0);
      put(REG_USER0);
      put(8'h00);
      mst.stop_c();
      cmd(CMD_RECALL);
      rd_chk(REG_USER0, 2, 32'h00001122);
   endtask
   // Soft reset keeps the nonvolatile image; gap and past-end handling
   task automatic t_por();
      cmd(CMD_START);
      cmd(CMD_POR);
      chk("converting", 8'h00, {7'h00, conv});
      chk("single select", 8'h01, {7'h00, single});
      rd_chk(REG_USER0, 1, 32'h00000000);
      cmd(CMD_RECALL);
      rd_chk(REG_USER0, 1, 32'h00000011);
      mst.start_c();
      ctrl(1'b0);
      put(REG_GAP0);
      put(8'h5A);
      put(8'h5A);
      put(8'h5A);
      mst.stop_c();
      rd_chk(REG_GAP0, 3, 32'h0000005A);
      rd_chk(REG_LAST, 2, 32'h000000FF);
   endtask
   initial
   begin
      i_rst_b = 1'b0;
      repeat (8) @(negedge i_sys_clk);
      i_rst_b = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      t_reset();
      t_bad_addr();
      t_single();
      t_user_write();
      t_copy();
      t_por();
      close_out();
   end
endmodule
